/* smc_sleep_ctrl.sv */
`timescale 1ns/1ps
`include "smc_defs.svh"
// Functional notes
// - Code 000 enters Idle: core and program memory clocks stop, others run.
// - Idle wakes on any enabled interrupt, external or internal.
// - Entering Idle or converter noise reduction with converter enabled starts a conversion.
// - Code 001 stops io, core and program memory clocks; converter and async run.
// - Noise reduction wakes only on the listed converter, display, timer2, serial, memory-ready, pin events.
// - Code 010 enters Power-down: oscillator and all generated clocks stop.
// - Power-down wakes only on reset, serial start, external_irq_0 level, pin change.
// - Leaving Power-down waits a start-up delay chosen by control bit SMC_CTRL_LONG_START.
// - Code 011 enters Power-save: like Power-down, timer2 and display keep running.
// - Power-save timer2 wake needs its mask bit and global enable; display wakes.
// - Power-save stops the timer oscillator if no user selects async clock.
// - Power-save stops main source unless a user needs sync clock; only they get it.
// - Code 110 with crystal enters Standby: oscillator runs, wake in six cycles.
// - Comparator disable powers comparator down and removes it as Idle wake source.
// - Sleep is entered only if control bit SMC_CTRL_ARM is one when sleep executes.
// - After wake the core halts four cycles beyond start-up, then serves interrupt.
module smc_sleep_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    input wire logic sleep_exec,
    input wire logic global_irq_en,
    input wire logic [1:0] timer2_irq_mask,
    output logic cpu_halt,
    output logic wake_irq_go,
    // Peripheral side
    input wire smc_pkg::smc_wake_t wake_ev,
    input wire logic adc_en,
    input wire logic lcd_en,
    input wire logic t2_en,
    input wire logic ext_external_irq_0_level,
    input wire logic pin_change,
    input wire logic reset_wake,
    output logic adc_start,
    output logic comparator_disable,
    output smc_pkg::smc_clk_en_t clk_en,
    // Interrupt
    output logic irq
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    // Pins come from outside the clock domain; only sync2 is read by logic
    always_comb begin
        nxt_sync1 = {reset_wake, pin_change, ext_external_irq_0_level};
        nxt_sync2 = sync1_ff;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end
    // ----------------------------------------
    // Registers and APB
    // ----------------------------------------
    logic [`SMC_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [`SMC_IRQ_W-1:0] istat_ff, nxt_istat, imask_ff, nxt_imask, ev_set;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [31:0] status_word;
    logic wr_go, setup, hit;
    smc_pkg::smc_state_t state_ff, nxt_state;
    logic [2:0] mode_ff, nxt_mode;
    smc_pkg::smc_clk_en_t clk_ff, nxt_clk;
    logic [2:0] arm_mode;
    assign arm_mode = ctrl_ff[`SMC_CTRL_MODE_HI:`SMC_CTRL_MODE_LO];
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pwrite;
    assign hit = (paddr == `SMC_CTRL_ADDR) || (paddr == `SMC_STATUS_ADDR) ||
                 (paddr == `SMC_ISTAT_ADDR) || (paddr == `SMC_IMASK_ADDR);
    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_ff;
    assign status_word = {18'h0_0000, clk_ff, mode_ff, state_ff};
    // Read data is captured in the setup cycle so it comes from a flop
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup && !pwrite) begin
            unique case (paddr)
                `SMC_CTRL_ADDR: nxt_prdata = {23'h00_0000, ctrl_ff};
                `SMC_STATUS_ADDR: nxt_prdata = status_word;
                `SMC_ISTAT_ADDR: nxt_prdata = {29'h0000_0000, istat_ff};
                `SMC_IMASK_ADDR: nxt_prdata = {29'h0000_0000, imask_ff};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end
    // Control, mask and sticky status; a new event wins over a clear
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_imask = imask_ff;
        nxt_istat = istat_ff;
        if (wr_go && paddr == `SMC_CTRL_ADDR) begin
            nxt_ctrl = pwdata[`SMC_CTRL_W-1:0];
        end
        if (wr_go && paddr == `SMC_IMASK_ADDR) begin
            nxt_imask = pwdata[`SMC_IRQ_W-1:0];
        end
        if (wr_go && paddr == `SMC_ISTAT_ADDR) begin
            nxt_istat = istat_ff & ~pwdata[`SMC_IRQ_W-1:0];
        end
        nxt_istat = nxt_istat | ev_set;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_ff <= `SMC_CTRL_RST;
            imask_ff <= `SMC_IRQ_RST;
            istat_ff <= `SMC_IRQ_RST;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            imask_ff <= nxt_imask;
            istat_ff <= nxt_istat;
            prdata_ff <= nxt_prdata;
        end
    end
    assign irq = |(istat_ff & imask_ff);
    assign comparator_disable = ctrl_ff[`SMC_CTRL_CMP_DIS];
    // ----------------------------------------
    // Wake qualification
    // ----------------------------------------
    logic wake_ok, t2_wake, lcd_async_on, t2_async_on, lcd_sync_on, t2_sync_on;
    assign t2_wake = global_irq_en && ((wake_ev.t2_ovf && timer2_irq_mask[0]) ||
                     (wake_ev.t2_cmp && timer2_irq_mask[1]));
    assign lcd_async_on = lcd_en && ctrl_ff[`SMC_CTRL_LCD_ASYNC];
    assign t2_async_on = t2_en && ctrl_ff[`SMC_CTRL_T2_ASYNC];
    assign lcd_sync_on = lcd_en && !ctrl_ff[`SMC_CTRL_LCD_ASYNC];
    assign t2_sync_on = t2_en && !ctrl_ff[`SMC_CTRL_T2_ASYNC];
    // Per-mode wake source set
    always_comb begin
        wake_ok = 1'b0;
        unique case (mode_ff)
            `SMC_MODE_IDLE: wake_ok = wake_ev.irq_pending || (|sync2_ff) ||
                (wake_ev.comp_irq && !ctrl_ff[`SMC_CTRL_CMP_DIS]);
            `SMC_MODE_ADCNR: wake_ok = wake_ev.adc_done || wake_ev.lcd_irq ||
                wake_ev.usi_start || wake_ev.t2_ovf || wake_ev.t2_cmp ||
                wake_ev.spm_ready || (|sync2_ff);
            `SMC_MODE_PSAVE: wake_ok = wake_ev.usi_start || (|sync2_ff) ||
                t2_wake || wake_ev.lcd_irq;
            default: wake_ok = wake_ev.usi_start || (|sync2_ff);
        endcase
    end
    // ----------------------------------------
    // Sleep sequencer
    // ----------------------------------------
    logic [`SMC_CNT_W-1:0] cnt_ff, nxt_cnt, start_cyc;
    logic mode_legal, enter;
    logic adc_start_ff, nxt_adc_start, go_ff, nxt_go;
    assign mode_legal = (arm_mode == `SMC_MODE_IDLE) || (arm_mode == `SMC_MODE_ADCNR) ||
                        (arm_mode == `SMC_MODE_PDOWN) || (arm_mode == `SMC_MODE_PSAVE) ||
                        (arm_mode == `SMC_MODE_STBY && ctrl_ff[`SMC_CTRL_CRYSTAL]);
    assign enter = sleep_exec && ctrl_ff[`SMC_CTRL_ARM] && mode_legal;
    // Long start-up count still fits the 18-bit counter, so one counter serves all waits
    assign start_cyc = ctrl_ff[`SMC_CTRL_LONG_START] ?
                       `SMC_CNT_W'(`SMC_LONG_START_CYC) :
                       `SMC_CNT_W'(`SMC_SHORT_START_CYC);
    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_cnt = cnt_ff;
        nxt_adc_start = 1'b0;
        nxt_go = 1'b0;
        ev_set = 3'h0;
        unique case (state_ff)
            smc_pkg::SMC_RUN: begin
                if (enter) begin
                    nxt_state = smc_pkg::SMC_SLEEP;
                    nxt_mode = arm_mode;
                    ev_set[`SMC_IRQ_ENTER] = 1'b1;
                    nxt_adc_start = adc_en && (arm_mode == `SMC_MODE_IDLE ||
                                    arm_mode == `SMC_MODE_ADCNR);
                end else if (sleep_exec) begin
                    ev_set[`SMC_IRQ_REFUSE] = 1'b1;
                end
            end
            smc_pkg::SMC_SLEEP: begin
                if (wake_ok) begin
                    nxt_state = smc_pkg::SMC_WAKE;
                    ev_set[`SMC_IRQ_WAKE] = 1'b1;
                    // Running oscillator needs no restart; Standby needs six cycles
                    if (mode_ff == `SMC_MODE_PDOWN || mode_ff == `SMC_MODE_PSAVE) begin
                        nxt_cnt = start_cyc;
                    end else if (mode_ff == `SMC_MODE_STBY) begin
                        nxt_cnt = `SMC_CNT_W'(`SMC_STBY_CYC);
                    end else begin
                        nxt_cnt = `SMC_CNT_ONE;
                    end
                end
            end
            smc_pkg::SMC_WAKE: begin
                nxt_cnt = cnt_ff - `SMC_CNT_ONE;
                if (cnt_ff == `SMC_CNT_ONE) begin
                    nxt_state = smc_pkg::SMC_HALT;
                    nxt_cnt = `SMC_CNT_W'(`SMC_HALT_CYC);
                end
            end
            smc_pkg::SMC_HALT: begin
                nxt_cnt = cnt_ff - `SMC_CNT_ONE;
                if (cnt_ff == `SMC_CNT_ONE) begin
                    nxt_state = smc_pkg::SMC_RUN;
                    nxt_go = 1'b1;
                end
            end
            default: nxt_state = smc_pkg::SMC_RUN;
        endcase
    end
    // ----------------------------------------
    // Clock gating per state and mode
    // ----------------------------------------
    always_comb begin
        nxt_clk = '1;
        if (nxt_state == smc_pkg::SMC_SLEEP || nxt_state == smc_pkg::SMC_WAKE) begin
            nxt_clk.core = 1'b0;
            nxt_clk.prog_mem = 1'b0;
            unique case (nxt_mode)
                `SMC_MODE_IDLE: ;
                `SMC_MODE_ADCNR: nxt_clk.periph_io = 1'b0;
                default: begin
                    nxt_clk.periph_io = 1'b0;
                    nxt_clk.converter = 1'b0;
                    nxt_clk.async_timer = 1'b0;
                    nxt_clk.timer_osc = 1'b0;
                    nxt_clk.lcd_t2_sync = 1'b0;
                    nxt_clk.main_osc = (nxt_mode == `SMC_MODE_STBY);
                    if (nxt_mode == `SMC_MODE_PSAVE) begin
                        nxt_clk.async_timer = lcd_async_on || t2_async_on;
                        nxt_clk.timer_osc = lcd_async_on || t2_async_on;
                        nxt_clk.lcd_t2_sync = lcd_sync_on || t2_sync_on;
                        nxt_clk.main_osc = lcd_sync_on || t2_sync_on;
                    end
                end
            endcase
            // Oscillator restarts for the start-up count
            if (nxt_state == smc_pkg::SMC_WAKE) begin
                nxt_clk.main_osc = 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= smc_pkg::SMC_RUN;
            mode_ff <= 3'h0;
            cnt_ff <= '0;
            adc_start_ff <= 1'b0;
            go_ff <= 1'b0;
            clk_ff <= '1;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            cnt_ff <= nxt_cnt;
            adc_start_ff <= nxt_adc_start;
            go_ff <= nxt_go;
            clk_ff <= nxt_clk;
        end
    end
    assign clk_en = clk_ff;
    assign adc_start = adc_start_ff;
    assign wake_irq_go = go_ff;
    assign cpu_halt = (state_ff != smc_pkg::SMC_RUN);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_halt4;
        (state_ff == smc_pkg::SMC_HALT) [*4] ##1 (state_ff == smc_pkg::SMC_RUN);
    endsequence
    idle_gating_a: assert property ((state_ff == smc_pkg::SMC_SLEEP &&
        mode_ff == `SMC_MODE_IDLE) |-> (!clk_en.core && clk_en.periph_io &&
        clk_en.converter && clk_en.main_osc)) else $error("idle gating wrong");
    adcnr_gating_a: assert property ((state_ff == smc_pkg::SMC_SLEEP &&
        mode_ff == `SMC_MODE_ADCNR) |-> (!clk_en.periph_io && clk_en.converter))
        else $error("noise reduction gating wrong");
    pdown_gating_a: assert property ((state_ff == smc_pkg::SMC_SLEEP &&
        mode_ff == `SMC_MODE_PDOWN) |-> (!clk_en.main_osc && !clk_en.converter &&
        !clk_en.timer_osc)) else $error("power-down gating wrong");
    adc_kick_a: assert property ((state_ff == smc_pkg::SMC_RUN && enter && adc_en &&
        arm_mode == `SMC_MODE_IDLE) |=> adc_start) else $error("no converter start");
    arm_needed_a: assert property ((state_ff == smc_pkg::SMC_RUN &&
        !ctrl_ff[`SMC_CTRL_ARM]) |=> state_ff == smc_pkg::SMC_RUN)
        else $error("slept without arm");
    reserved_nop_a: assert property ((state_ff == smc_pkg::SMC_RUN && sleep_exec &&
        !mode_legal) |=> (state_ff == smc_pkg::SMC_RUN && clk_en.core))
        else $error("reserved code slept");
    halt_four_a: assert property ($rose(state_ff == smc_pkg::SMC_HALT) |-> s_halt4)
        else $error("halt not four cycles");
    stby_six_a: assert property ((state_ff == smc_pkg::SMC_SLEEP &&
        mode_ff == `SMC_MODE_STBY && wake_ok) |-> ##7 state_ff == smc_pkg::SMC_HALT)
        else $error("standby wake not six cycles");
    psave_t2_a: assert property ((state_ff == smc_pkg::SMC_SLEEP &&
        mode_ff == `SMC_MODE_PSAVE && !global_irq_en && !wake_ev.lcd_irq &&
        !wake_ev.usi_start && !(|sync2_ff)) |=> state_ff == smc_pkg::SMC_SLEEP)
        else $error("power-save woke without enable");
    psave_osc_a: assert property ((state_ff == smc_pkg::SMC_SLEEP &&
        mode_ff == `SMC_MODE_PSAVE && $stable(ctrl_ff) && $stable({lcd_en, t2_en}))
        |-> (clk_en.timer_osc == (lcd_async_on || t2_async_on) &&
        clk_en.main_osc == (lcd_sync_on || t2_sync_on)))
        else $error("power-save oscillator wrong");
endmodule : smc_sleep_ctrl

/* smc_defs.svh */
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
// Register byte addresses
`define SMC_CTRL_ADDR 12'h000
`define SMC_STATUS_ADDR 12'h004
`define SMC_ISTAT_ADDR 12'h008
`define SMC_IMASK_ADDR 12'h00C
// Control register fields
`define SMC_CTRL_ARM 0
`define SMC_CTRL_MODE_LO 1
`define SMC_CTRL_MODE_HI 3
`define SMC_CTRL_CMP_DIS 4
`define SMC_CTRL_CRYSTAL 5
`define SMC_CTRL_LONG_START 6
`define SMC_CTRL_LCD_ASYNC 7
`define SMC_CTRL_T2_ASYNC 8
`define SMC_CTRL_W 9
`define SMC_CTRL_RST 9'h000
// Status and interrupt fields
`define SMC_ST_STATE_LO 0
`define SMC_ST_MODE_LO 3
`define SMC_ST_CLK_LO 6
`define SMC_IRQ_ENTER 0
`define SMC_IRQ_WAKE 1
`define SMC_IRQ_REFUSE 2
`define SMC_IRQ_W 3
`define SMC_IRQ_RST 3'h0
// Sleep mode codes
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_ADCNR 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_STBY 3'h6
// Timing
`define SMC_CLK_MHZ 40
`define SMC_SHORT_START_US 100
`define SMC_LONG_START_US 4100
`define SMC_SHORT_START_CYC (`SMC_SHORT_START_US * `SMC_CLK_MHZ)
`define SMC_LONG_START_CYC (`SMC_LONG_START_US * `SMC_CLK_MHZ)
`define SMC_STBY_CYC 6
`define SMC_HALT_CYC 4
`define SMC_CNT_W 18
`define SMC_CNT_ONE 18'h0_0001
`endif

/* smc_pkg.sv */
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_RUN = 3'b000,
        SMC_SLEEP = 3'b001,
        SMC_WAKE = 3'b010,
        SMC_HALT = 3'b011
    } smc_state_t;
    // Clock domain and oscillator enables
    typedef struct packed {
        logic core;
        logic prog_mem;
        logic periph_io;
        logic converter;
        logic async_timer;
        logic main_osc;
        logic timer_osc;
        logic lcd_t2_sync;
    } smc_clk_en_t;
    // Wake events from logic on the same clock
    typedef struct packed {
        logic irq_pending;
        logic adc_done;
        logic lcd_irq;
        logic usi_start;
        logic t2_ovf;
        logic t2_cmp;
        logic spm_ready;
        logic comp_irq;
    } smc_wake_t;
endpackage : smc_pkg

/* smc_far_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Core and wake source model
// ----------------------------------------
module smc_far_model (
    // Clock
    input wire logic clk,
    // Core view
    input wire logic core_on,
    input wire logic wake_irq_go,
    output logic sleep_exec,
    // Wake sources: 0..7 event bits, 8 external_irq_0 level, 9 pin change, 10 reset
    output logic [10:0] src
);
    initial begin
        sleep_exec = 1'b0;
        src = '0;
    end

    // One sleep instruction is a single-cycle pulse
    task automatic sleep_once();
        @(posedge clk) sleep_exec <= 1'b1;
        @(posedge clk) sleep_exec <= 1'b0;
    endtask : sleep_once

    // Hold a source until the handler runs or the limit ends; a level
    // that drops early would be lost in the pin synchroniser
    task automatic try_wake(input int s, input int lim, output int go_k, output int on_k);
        int k;
        go_k = 0;
        on_k = 0;
        @(posedge clk) src[s] <= 1'b1;
        for (k = 1; k <= lim && go_k == 0; k++) begin
            @(negedge clk);
            if (core_on === 1'b1 && on_k == 0) on_k = k;
            if (wake_irq_go === 1'b1) go_k = k;
        end
        @(posedge clk) src[s] <= 1'b0;
    endtask : try_wake
endmodule : smc_far_model

/* sleep_mode_clock_gating_bench.sv */
`timescale 1ns/1ps
`include "smc_defs.svh"
module sleep_mode_clock_gating_bench;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic global_irq_en, adc_en, lcd_en, t2_en, cpu_halt, wake_irq_go, adc_start, cmp_dis, irq;
    logic [1:0] t2_mask;
    logic sleep_exec;
    logic [10:0] src;
    smc_pkg::smc_clk_en_t clk_en;
    int mismatches, check_count, go_k, on_k, i;

    smc_sleep_ctrl smc_sleep_ctrl_inst (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .global_irq_en(global_irq_en), .timer2_irq_mask(t2_mask),
        .cpu_halt(cpu_halt), .wake_irq_go(wake_irq_go),
        .wake_ev(smc_pkg::smc_wake_t'(src[7:0])), .adc_en(adc_en), .lcd_en(lcd_en),
        .t2_en(t2_en), .ext_external_irq_0_level(src[8]), .pin_change(src[9]), .reset_wake(src[10]),
        .adc_start(adc_start), .comparator_disable(cmp_dis), .clk_en(clk_en), .irq(irq)
    );
    smc_far_model smc_far_model_inst (
        .clk(clk), .core_on(clk_en.core), .wake_irq_go(wake_irq_go),
        .sleep_exec(sleep_exec), .src(src)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_word

    // Request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait-state count is assumed; only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Cycles from raising a source to the handler go; pins pay the synchroniser
    function automatic int due(input int s, input int len);
        return 6 + len + ((s >= 8) ? 2 : 0);
    endfunction : due

    task automatic enter(input logic [31:0] ctl, input logic [7:0] msk, input logic [7:0] exp);
        apb(1'b1, `SMC_CTRL_ADDR, ctl);
        smc_far_model_inst.sleep_once();
        // Converter start is a one-cycle pulse, so look in the entry cycle
        @(negedge clk);
        check_word(cpu_halt, 1'b1, "halt");
        check_word({clk_en} & msk, exp & msk, "gating");
        check_word(adc_start, adc_en & (ctl[3:2] == 2'b00), "conv start");
    endtask : enter

    // Zero expected cycles means the source must not wake the core
    task automatic wake(input int s, input int lim, input int exp);
        smc_far_model_inst.try_wake(s, lim, go_k, on_k);
        check_word(go_k, exp, "wake time");
        if (exp > 0) check_word(go_k - on_k, 4, "halt span");
        repeat (4) @(posedge clk);
    endtask : wake

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(1'b0, `SMC_ISTAT_ADDR, 32'h0000_0000);
        check_word(rd, 32'h0000_0000, "istat reset");
        apb(1'b1, `SMC_CTRL_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, `SMC_CTRL_ADDR, 32'h0000_0000);
        check_word(rd, 32'h0000_01FF, "ctrl bits");
        check_word(cmp_dis, 1'b1, "comparator off");
        apb(1'b0, 12'h010, 32'h0000_0000);
        check_word(err, 1'b1, "unmapped err");
        check_word(rd, 32'h0000_0000, "unmapped data");
    endtask : t_regs

    // Disarmed, reserved and crystal-less standby requests are refused
    task automatic t_refuse();
        logic [31:0] bad [5] = '{32'h0000_0000, 32'h0000_0009, 32'h0000_000B,
                                  32'h0000_000F, 32'h0000_000D};
        apb(1'b1, `SMC_IMASK_ADDR, 32'h0000_0004);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, `SMC_CTRL_ADDR, bad[i]);
            smc_far_model_inst.sleep_once();
            repeat (2) @(posedge clk);
            @(negedge clk);
            check_word(cpu_halt, 1'b0, "no sleep");
            check_word({clk_en}, 32'h0000_00FF, "no gating");
            check_word(irq, 1'b1, "refuse irq");
            apb(1'b1, `SMC_ISTAT_ADDR, 32'h0000_0004);
            @(negedge clk);
            check_word(irq, 1'b0, "irq cleared");
        end
        apb(1'b1, `SMC_IMASK_ADDR, 32'h0000_0000);
    endtask : t_refuse

    task automatic t_idle();
        adc_en <= 1'b1;
        enter(32'h0000_0011, 8'hFC, 8'h3C);
        wake(0, 20, 0);
        wake(7, 40, due(7, 1));
        apb(1'b0, `SMC_ISTAT_ADDR, 32'h0000_0000);
        check_word(rd, 32'h0000_0003, "enter and wake");
        apb(1'b1, `SMC_ISTAT_ADDR, 32'h0000_0003);
        enter(32'h0000_0001, 8'hFC, 8'h3C);
        wake(0, 40, due(0, 1));
    endtask : t_idle

    task automatic t_adcnr();
        int pos [6] = '{6, 4, 1, 8, 9, 10};
        for (i = 0; i < 6; i++) begin
            enter(32'h0000_0003, 8'hFC, 8'h1C);
            if (i == 0) wake(7, 20, 0);
            if (i == 0) wake(0, 20, 0);
            wake(pos[i], 40, due(pos[i], 1));
        end
    endtask : t_adcnr

    task automatic t_pdown();
        int neg [5] = '{6, 5, 3, 1, 7};
        adc_en <= 1'b0;
        enter(32'h0000_0005, 8'hFF, 8'h00);
        for (i = 0; i < 5; i++) wake(neg[i], 20, 0);
        wake(4, 4100, due(4, `SMC_SHORT_START_CYC));
        enter(32'h0000_0005, 8'hFF, 8'h00);
        wake(10, 4100, due(10, `SMC_SHORT_START_CYC));
    endtask : t_pdown

    // Both timer users on the async clock, then both on the sync clock
    task automatic t_psave();
        enter(32'h0000_0187, 8'hFF, 8'h0A);
        global_irq_en <= 1'b0;
        wake(3, 20, 0);
        global_irq_en <= 1'b1;
        t2_mask <= 2'b10;
        wake(3, 20, 0);
        t2_mask <= 2'b01;
        wake(2, 20, 0);
        t2_mask <= 2'b11;
        wake(3, 4100, due(3, `SMC_SHORT_START_CYC));
        enter(32'h0000_0007, 8'h07, 8'h05);
        wake(5, 4100, due(5, `SMC_SHORT_START_CYC));
    endtask : t_psave

    task automatic t_stby();
        enter(32'h0000_002D, 8'hFF, 8'h04);
        // Status while asleep: gating 0x04, mode 110, state sleep
        apb(1'b0, `SMC_STATUS_ADDR, 32'h0000_0000);
        check_word(rd, 32'h0000_0131, "standby status");
        wake(6, 20, 0);
        wake(9, 40, due(9, `SMC_STBY_CYC));
    endtask : t_stby

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        global_irq_en = 1'b1;
        t2_mask = 2'b11;
        adc_en = 1'b0;
        lcd_en = 1'b1;
        t2_en = 1'b1;
        mismatches = 0;
        check_count = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check_word({clk_en}, 32'h0000_00FF, "reset clocks");
        check_word({cpu_halt, irq, adc_start, wake_irq_go}, 32'h0000_0000, "reset outputs");
        t_regs();
        t_refuse();
        t_idle();
        t_adcnr();
        t_pdown();
        t_psave();
        t_stby();
        complete_run();
    end

    // Longest path is four start-up waits of a few thousand cycles
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule : sleep_mode_clock_gating_bench
